// [hw/pfci_pkg.sv]
// shared constants and types for the pixel flow-control link
// assumes one 20 MHz clock on both ends, all link lines timed on its rising edge
package pfci_pkg;
    localparam int unsigned PIX_W      = 12;
    localparam int unsigned COMP_W     = 2;
    localparam int unsigned FIFO_W     = PIX_W + COMP_W;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned BLK_LAST   = 63;   // samples 0..63 per 8x8 block
    localparam int unsigned ENC_LEAD   = 42;   // encoder hold-off lead, cycles
    localparam int unsigned DEC_LEAD   = 24;   // sink hold-off lead, cycles
    localparam int unsigned LINK_SLACK = 6;    // two synchronisers and output flops
    localparam int unsigned RESUME_GAP = 17;   // cycles after hold-off release
    localparam int unsigned FULL_BUFS  = 3;
    localparam int unsigned NUM_BUFS   = 4;
    localparam logic [5:0] ENC_HOLD_IDX = 6'(BLK_LAST - ENC_LEAD);
    localparam logic [5:0] DEC_HOLD_IDX = 6'(BLK_LAST - DEC_LEAD - LINK_SLACK);
    localparam logic [1:0] COMP_IDLE    = 2'h3;

    typedef enum logic [5:0] {
        PF_IDLE     = 6'h01,
        PF_ENC_BLK  = 6'h02,
        PF_ENC_LSL  = 6'h04,
        PF_DEC_BLK  = 6'h08,
        PF_DEC_PRV  = 6'h10,
        PF_DEC_LSL  = 6'h20
    } pfci_mode_e;

    typedef enum logic [1:0] {
        ST_WAIT = 2'h1,
        ST_DATA = 2'h2
    } pfci_state_e;
endpackage

// [hw/pfci_if.sv]
// link between the compression end and the pixel partner
// assumes one drives each shared line at a time; undriven lines idle high or zero
`timescale 1ns/1ps
interface pfci_if;
    import pfci_pkg::*;
    logic             holdN;
    logic             devHold,  devHoldOe,  hostHold,  hostHoldOe;
    logic             syncN;
    logic             devSync,  devSyncOe,  hostSync,  hostSyncOe;
    logic [PIX_W-1:0] pixel;
    logic [PIX_W-1:0] devPix,   hostPix;
    logic             devPixOe, hostPixOe;
    logic             pixValid, devValid,   hostValid;
    logic [1:0]       compIdx;
    logic             eosN;

    // wire resolution, pull-ups on hold-off and sync, pixel and valid idle low
    assign holdN    = devHoldOe ? devHold : (hostHoldOe ? hostHold : 1'b1);
    assign syncN    = devSyncOe ? devSync : (hostSyncOe ? hostSync : 1'b1);
    assign pixel    = devPixOe ? devPix : (hostPixOe ? hostPix : '0);
    assign pixValid = devPixOe ? devValid : (hostPixOe ? hostValid : 1'b0);

    modport dev  (input holdN, syncN, pixel, pixValid,
                  output devHold, devHoldOe, devSync, devSyncOe, devPix, devPixOe, devValid,
                  compIdx, eosN);
    modport host (input holdN, syncN, pixel, pixValid, compIdx, eosN,
                  output hostHold, hostHoldOe, hostSync, hostSyncOe, hostPix, hostPixOe,
                  hostValid);
endinterface

// [hw/pfci_fifo.sv]
// flop-based fifo with valid/ready on both sides
// assumes both sides on sys_clk
`timescale 1ns/1ps
module pfci_fifo #(
    parameter int unsigned WIDTH = 14,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int unsigned AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wp;
        logic [AW-1:0]               rp;
        logic [AW:0]                 cnt;
    } pfci_fifo_s;
    pfci_fifo_s s_q, s_d;
    logic push, pop;

    // honest full/empty from the occupancy count
    assign inReady  = (s_q.cnt != (AW+1)'(DEPTH));
    assign outValid = (s_q.cnt != '0);
    assign outData  = s_q.mem[s_q.rp];
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.mem[s_q.wp] = inData;
            s_d.wp          = s_q.wp + 1'b1;
        end
        if (pop) begin
            s_d.rp = s_q.rp + 1'b1;
        end
        s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule // pfci_fifo

// [hw/pfci_device.sv]
// compression-processor end of the pixel link: hold-off, block sync, component index
// assumes link inputs come from the partner's flops; each is synchronised twice
`timescale 1ns/1ps
module pfci_device
    import pfci_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              reset,
    pfci_if.dev                    link,
    input  wire pfci_mode_e        mode,
    input  wire logic              paramBusy,
    input  wire logic              bufFree,
    output logic       [PIX_W-1:0] encData,
    output logic                   encValid,
    input  wire logic              encReady,
    input  wire logic              decValid,
    output logic                   decReady,
    input  wire logic  [FIFO_W-1:0] decData,
    input  wire logic              scanEnd,
    output logic       [2:0]       bufUsed
);
    typedef struct packed {
        logic             hs1, hs2, ss1, ss2, vs1, vs2;
        logic [PIX_W-1:0] ps1, ps2;
        pfci_state_e      st;
        logic [5:0]       idx;
        logic [4:0]       gap;
        logic [2:0]       occ;
        logic             eosPend;
        logic             hold, holdOe, sync, syncOe, pixOe, valid, end_of_scan;
        logic [PIX_W-1:0] pix, enc;
        logic             encV;
        logic [1:0]       comp;
    } pfci_dev_s;
    pfci_dev_s s_q, s_d;

    logic              fValid, fPop;
    logic [FIFO_W-1:0] fData;
    logic              isEnc, isDec, perSample;

    // decoded samples wait here; the link side stalls on hold-off
    pfci_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .inValid  (decValid),
        .inReady  (decReady),
        .inData   (decData),
        .outValid (fValid),
        .outReady (fPop),
        .outData  (fData)
    );

    assign isEnc     = (mode == PF_ENC_BLK) | (mode == PF_ENC_LSL);
    assign isDec     = ~isEnc & (mode != PF_IDLE);
    assign perSample = (mode == PF_DEC_PRV) | (mode == PF_DEC_LSL);
    assign fPop      = isDec & (s_q.st == ST_DATA) & fValid;

    always_comb begin
        s_d = s_q;
        // two flops on every link input before use
        s_d.hs1 = link.holdN;
        s_d.hs2 = ~s_q.hs1;                                   // stored active high
        s_d.ss1 = link.syncN;
        s_d.ss2 = ~s_q.ss1;
        s_d.vs1 = link.pixValid;
        s_d.vs2 = s_q.vs1;
        s_d.ps1 = link.pixel;
        s_d.ps2 = s_q.ps1;
        s_d.sync = 1'b1;
        s_d.end_of_scan  = 1'b1;
        s_d.valid = 1'b0;
        s_d.encV  = 1'b0;
        // hold-off direction follows the mode; device drives it outside decode
        s_d.holdOe = ~isDec;
        s_d.syncOe = isDec;
        s_d.pixOe  = isDec;
        if (scanEnd) begin
            s_d.eosPend = 1'b1;
        end
        if (!isDec) begin
            s_d.st   = ST_WAIT;
            s_d.comp = COMP_IDLE;                             // no meaning in encode
            s_d.gap  = '0;
        end
        if (mode == PF_IDLE) begin
            s_d.occ  = '0;
            s_d.hold = 1'b0;                                  // idle: not ready
        end else if (isEnc) begin
            // buffer occupancy: a block claims one at its sync, datapath frees one
            s_d.occ = s_q.occ + 3'(s_q.ss2 & (mode == PF_ENC_BLK)) - 3'(bufFree && s_q.occ != 0);
            if (s_q.ss2) begin
                s_d.idx = '0;
            end
            if (s_q.vs2) begin
                s_d.enc  = s_q.ps2;
                s_d.encV = 1'b1;
                s_d.idx  = s_q.idx + 1'b1;
            end
            if (paramBusy) begin
                s_d.hold = 1'b0;                              // parameters in work
            end else if (mode == PF_ENC_LSL) begin
                s_d.hold = encReady;                          // sink back-pressure to source
            end else if (s_q.vs2 && s_q.idx == ENC_HOLD_IDX && s_q.occ >= 3'(FULL_BUFS)) begin
                s_d.hold = 1'b0;                              // lead before last sample
            end else if (s_d.occ < 3'(FULL_BUFS)) begin
                s_d.hold = 1'b1;                              // a buffer came free
            end
        end else begin
            s_d.hold = 1'b1;
            s_d.occ  = '0;
            // resume gap restarts while the sink still holds off
            if (s_q.hs2) begin
                s_d.gap = 5'(RESUME_GAP);
            end else if (s_q.gap != '0) begin
                s_d.gap = s_q.gap - 1'b1;
            end
            case (s_q.st)
                ST_WAIT: begin
                    if (fValid && !s_q.hs2 && (perSample || s_q.gap == '0)) begin
                        s_d.sync = 1'b0;                      // one cycle ahead of data
                        s_d.comp = fData[FIFO_W-1:PIX_W];
                        s_d.idx  = '0;
                        s_d.st   = ST_DATA;
                    end else if (!fValid && s_q.eosPend) begin
                        s_d.end_of_scan     = 1'b0;
                        s_d.comp    = COMP_IDLE;              // scan over, index idles
                        s_d.eosPend = 1'b0;
                    end
                end
                ST_DATA: begin
                    if (fValid) begin
                        s_d.pix   = fData[PIX_W-1:0];
                        s_d.valid = 1'b1;
                        s_d.idx   = s_q.idx + 1'b1;
                        if (perSample || s_q.idx == 6'(BLK_LAST)) begin
                            s_d.st = ST_WAIT;                 // gated by hold-off next
                        end
                    end
                end
                default: begin
                    s_d.st = ST_WAIT;
                end
            endcase
            if (scanEnd) begin
                s_d.eosPend = 1'b1;                           // set wins over clear
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_q        <= '0;
            s_q.hs1    <= 1'b1;
            s_q.ss1    <= 1'b1;
            s_q.st     <= ST_WAIT;
            s_q.hold   <= 1'b0;
            s_q.holdOe <= 1'b1;
            s_q.sync   <= 1'b1;
            s_q.end_of_scan    <= 1'b1;
            s_q.comp   <= COMP_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // all outputs but decReady straight from flops
    assign link.devHold   = s_q.hold;
    assign link.devHoldOe = s_q.holdOe;
    assign link.devSync   = s_q.sync;
    assign link.devSyncOe = s_q.syncOe;
    assign link.devPix    = s_q.pix;
    assign link.devPixOe  = s_q.pixOe;
    assign link.devValid  = s_q.valid;
    assign link.compIdx   = s_q.comp;
    assign link.eosN      = s_q.end_of_scan;
    assign encData        = s_q.enc;
    assign encValid       = s_q.encV;
    assign bufUsed        = s_q.occ;
endmodule // pfci_device

// [hw/pfci_partner.sv]
// pixel source/sink end: sends blocks when encoding, takes them and holds off when decoding
// assumes device outputs are asynchronous to this end's flops, so all pass two flops
`timescale 1ns/1ps
module pfci_partner
    import pfci_pkg::*;
(
    input  wire logic             sys_clk,
    input  wire logic             reset,
    pfci_if.host                  link,
    input  wire pfci_mode_e       mode,
    input  wire logic             srcValid,
    output logic                  srcReady,
    input  wire logic [PIX_W-1:0] srcData,
    output logic      [PIX_W-1:0] sinkData,
    output logic                  sinkValid,
    output logic      [1:0]       sinkComp,
    output logic                  scanDone,
    input  wire logic             pauseReq
);
    typedef struct packed {
        logic             hs1, hs2, ds1, ds2, vs1, vs2, es1, es2;
        logic [PIX_W-1:0] ps1, ps2;
        logic [1:0]       cs1, cs2;
        pfci_state_e      st;
        logic [5:0]       cnt;
        logic             inBlk, held;
        logic             rdy, sync, syncOe, pixOe, valid, hold, holdOe;
        logic [PIX_W-1:0] pix, sData;
        logic             sValid, done;
        logic [1:0]       sComp;
    } pfci_host_s;
    pfci_host_s s_q, s_d;
    logic isEnc, lossless, take;

    assign isEnc    = (mode == PF_ENC_BLK) | (mode == PF_ENC_LSL);
    assign lossless = (mode == PF_ENC_LSL);
    assign take     = srcValid & s_q.rdy & (s_q.st == ST_DATA) & ~(lossless & s_q.hs2);

    always_comb begin
        s_d = s_q;
        s_d.hs1 = link.holdN;
        s_d.hs2 = ~s_q.hs1;
        s_d.ds1 = link.syncN;
        s_d.ds2 = ~s_q.ds1;
        s_d.vs1 = link.pixValid;
        s_d.vs2 = s_q.vs1;
        s_d.es1 = link.eosN;
        s_d.es2 = ~s_q.es1;
        s_d.ps1 = link.pixel;
        s_d.ps2 = s_q.ps1;
        s_d.cs1 = link.compIdx;
        s_d.cs2 = s_q.cs1;
        s_d.sync   = 1'b1;
        s_d.valid  = 1'b0;
        s_d.sValid = 1'b0;
        s_d.done   = s_q.es2;
        // hold-off driven only while decoding
        s_d.holdOe = ~isEnc & (mode != PF_IDLE);
        s_d.syncOe = isEnc;
        s_d.pixOe  = isEnc;
        if (isEnc) begin
            s_d.held = 1'b0;
            case (s_q.st)
                ST_WAIT: begin
                    // next block only once hold-off has gone
                    if (srcValid && !s_q.hs2) begin
                        s_d.sync = 1'b0;
                        s_d.cnt  = '0;
                        s_d.st   = ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (take) begin
                        s_d.pix   = srcData;
                        s_d.valid = 1'b1;
                        s_d.cnt   = s_q.cnt + 1'b1;
                        if (lossless || s_q.cnt == 6'(BLK_LAST)) begin
                            s_d.st = ST_WAIT;
                        end
                    end else if (lossless && s_q.hs2) begin
                        s_d.st = ST_WAIT;                     // stop by third cycle
                    end
                end
                default: begin
                    s_d.st = ST_WAIT;
                end
            endcase
        end else begin
            s_d.st = ST_WAIT;
            if (s_q.ds2) begin
                s_d.cnt   = '0;
                s_d.inBlk = (mode == PF_DEC_BLK);
                s_d.sComp = s_q.cs2;                          // index valid with sync
            end
            if (s_q.vs2) begin
                s_d.sData  = s_q.ps2;
                s_d.sValid = 1'b1;
                if (!s_q.ds2) begin
                    s_d.cnt = s_q.cnt + 1'b1;
                end
                if (s_q.cnt == 6'(BLK_LAST)) begin
                    s_d.inBlk = 1'b0;
                end
            end
            // assert early enough, keep until the block has ended
            if (pauseReq && (!s_q.inBlk || s_q.cnt < DEC_HOLD_IDX)) begin
                s_d.held = 1'b1;
            end else if (!pauseReq && !s_d.inBlk) begin
                s_d.held = 1'b0;
            end
        end
        s_d.hold = ~s_d.held;
        // no offer while lossless hold-off stands, so the source never loses a word
        s_d.rdy  = (s_d.st == ST_DATA) & ~(lossless & s_d.hs2);
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s_q      <= '0;
            s_q.hs1  <= 1'b1;
            s_q.ds1  <= 1'b1;
            s_q.es1  <= 1'b1;
            s_q.st   <= ST_WAIT;
            s_q.sync <= 1'b1;
            s_q.hold <= 1'b1;
            s_q.cs1  <= COMP_IDLE;
            s_q.cs2  <= COMP_IDLE;
            s_q.sComp <= COMP_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.hostHold   = s_q.hold;
    assign link.hostHoldOe = s_q.holdOe;
    assign link.hostSync   = s_q.sync;
    assign link.hostSyncOe = s_q.syncOe;
    assign link.hostPix    = s_q.pix;
    assign link.hostPixOe  = s_q.pixOe;
    assign link.hostValid  = s_q.valid;
    assign srcReady        = s_q.rdy;
    assign sinkData        = s_q.sData;
    assign sinkValid       = s_q.sValid;
    assign sinkComp        = s_q.sComp;
    assign scanDone        = s_q.done;
endmodule // pfci_partner

// [sim/pfci_checker.sv]
// concurrent checks on the pixel link between device and partner ends
// assumes it sits beside the interface, every line timed on sys_clk
`timescale 1ns/1ps
module pfci_checker
    import pfci_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       reset,
    input  wire pfci_mode_e mode,
    input  wire logic       holdN,
    input  wire logic       devHoldOe,
    input  wire logic       hostHoldOe,
    input  wire logic       syncN,
    input  wire logic       devSyncOe,
    input  wire logic       pixValid,
    input  wire logic [1:0] compIdx,
    input  wire logic       eosN
);
    localparam int GAP_MIN = 18;
    logic [4:0] relCnt_q;
    logic [4:0] relCnt_d;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    // cycles since hold-off last seen low, saturating so long idles never wrap
    always_comb begin
        relCnt_d = relCnt_q;
        if (!holdN)
            relCnt_d = 5'h00;
        else if (relCnt_q != 5'h1f)
            relCnt_d = relCnt_q + 5'h01;
    end

    always_ff @(posedge sys_clk) begin
        if (reset)
            relCnt_q <= 5'h1f;
        else
            relCnt_q <= relCnt_d;
    end

    a_sync_one_cycle: assert property ($fell(syncN) |=> syncN)
        else $error("block sync low longer than one cycle");
    a_hold_one_driver: assert property (!(devHoldOe && hostHoldOe))
        else $error("both ends drive hold-off");
    a_hold_enc_drive: assert property ((mode == PF_ENC_BLK) [*3] |-> devHoldOe)
        else $error("device not driving hold-off in encode");
    a_hold_dec_input: assert property ((mode == PF_DEC_BLK) [*3] |-> !devHoldOe)
        else $error("device drives hold-off in decode");
    a_idle_hold_off: assert property ((mode == PF_IDLE) [*3] |-> !holdN)
        else $error("hold-off released while idle");
    a_held_no_sync: assert property ((mode == PF_DEC_BLK && !holdN) [*5] |-> syncN)
        else $error("block sync issued under hold-off");
    a_resume_gap_min: assert property (mode == PF_DEC_BLK && devSyncOe && $fell(syncN)
        |-> relCnt_q >= GAP_MIN)
        else $error("block sync too soon after hold-off release");
    a_stream_stop_held: assert property
        ((mode inside {PF_DEC_PRV, PF_DEC_LSL} && !holdN) [*5] |-> !pixValid)
        else $error("samples still delivered under hold-off");
    a_index_moves_sync: assert property (mode inside {PF_DEC_BLK, PF_DEC_PRV, PF_DEC_LSL}
        && $stable(mode) && !$stable(compIdx) |-> (!syncN || !eosN))
        else $error("component index moved without sync or end of scan");
    a_eos_index_idle: assert property (!eosN |-> compIdx == COMP_IDLE)
        else $error("index not idle at end of scan");
    a_enc_index_idle: assert property
        ((mode == PF_ENC_BLK || mode == PF_ENC_LSL) [*3] |-> compIdx == COMP_IDLE)
        else $error("index not parked while encoding");

    // main scenarios reached
    c_dec_block_sync: cover property (mode == PF_DEC_BLK && devSyncOe && $fell(syncN));
    c_enc_hold_fall: cover property (mode == PF_ENC_BLK && $fell(holdN));
    c_sink_hold: cover property (hostHoldOe && !holdN);
    c_end_of_scan: cover property ($fell(eosN));
endmodule // pfci_checker

// [sim/tb_pfci.sv]
// self-checking bench: device and partner joined by the link interface
// assumes a 20 MHz sys_clk and synchronous active-high reset for both ends
`timescale 1ns/1ps
module tb_pfci;
    import pfci_pkg::*;
    logic              sys_clk   = 1'b0;
    logic              reset     = 1'b1;
    pfci_mode_e        mode      = PF_IDLE;
    logic              paramBusy = 1'b0, bufFree = 1'b0, scanEnd = 1'b0, pauseReq = 1'b0;
    logic              decValid  = 1'b0, srcValid = 1'b0;
    logic              encReady  = 1'b1;   // lossless back-pressure into the device
    logic [13:0]       decData   = 14'h0000;
    logic [11:0]       srcData   = 12'h000;
    logic [11:0]       encData,  sinkData;
    logic              encValid, decReady, srcReady, sinkValid, scanDone;
    logic [1:0]        sinkComp;
    logic [2:0]        bufUsed;
    logic [13:0]       txq[$],   rxq[$];
    int unsigned       nEnc = 0, nSink = 0, nPush = 0, nDone = 0, encBudget = 0, cyc = 0;
    int unsigned       fail_count = 0, check_count = 0, snap;
    int                fallPos = -1, gapRun = 0, gapSeen = 0;
    logic              prevHold = 1'b0, gapOn = 1'b0;

    always #25 sys_clk = ~sys_clk;

    pfci_if u_pfci_if ();
    pfci_device u_pfci_device (.sys_clk(sys_clk), .reset(reset), .link(u_pfci_if),
        .mode(mode), .paramBusy(paramBusy), .bufFree(bufFree), .encData(encData),
        .encValid(encValid), .encReady(encReady), .decValid(decValid), .decReady(decReady),
        .decData(decData), .scanEnd(scanEnd), .bufUsed(bufUsed));
    pfci_partner u_pfci_partner (.sys_clk(sys_clk), .reset(reset), .link(u_pfci_if),
        .mode(mode), .srcValid(srcValid), .srcReady(srcReady), .srcData(srcData),
        .sinkData(sinkData), .sinkValid(sinkValid), .sinkComp(sinkComp),
        .scanDone(scanDone), .pauseReq(pauseReq));
    pfci_checker u_pfci_checker (.sys_clk(sys_clk), .reset(reset), .mode(mode),
        .holdN(u_pfci_if.holdN), .devHoldOe(u_pfci_if.devHoldOe),
        .hostHoldOe(u_pfci_if.hostHoldOe), .syncN(u_pfci_if.syncN),
        .devSyncOe(u_pfci_if.devSyncOe), .pixValid(u_pfci_if.pixValid),
        .compIdx(u_pfci_if.compIdx), .eosN(u_pfci_if.eosN));

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: %s is %h, expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp, input string what);
        check_count++;
        if (got != exp) begin
            fail_count++;
            $display("Error at %0t: %s is %0d, expected %0d", $time, what, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // bounded wait on a counter kept by the monitor
    task automatic wait_cnt(ref int unsigned cnt, input int unsigned n);
        for (int i = 0; i < 3000 && cnt < n; i++) @(posedge sys_clk);
    endtask

    // write side: queue words for the fifo and the expected sink order
    task automatic send_words(input logic [1:0] comp, input logic [11:0] base, input int n);
        for (int i = 0; i < n; i++) begin
            txq.push_back({comp, base + 12'(i)});
            rxq.push_back({comp, base + 12'(i)});
        end
    endtask

    task automatic close_out();
        if (fail_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // drivers hold data until the handshake edge, then move to the next word
    always @(posedge sys_clk) begin
        if (decValid && decReady) begin
            void'(txq.pop_front());
            nPush++;
        end
        decValid <= (txq.size() > 0);
        decData  <= (txq.size() > 0) ? txq[0] : 14'h0000;
        if (srcValid && srcReady) begin
            srcData <= srcData + 12'h001;
            encBudget = encBudget - 1;
        end
        srcValid <= (encBudget != 0);
    end

    // monitor: data order, pulse counts, hold-off timing on the wire
    always @(posedge sys_clk) begin
        if (encValid) begin
            chk_val({4'h0, encData}, {4'h0, nEnc[11:0]}, "encode sample");
            nEnc++;
        end
        if (sinkValid) begin
            chk_val({2'h0, sinkComp, sinkData}, {2'h0, rxq[0]}, "sink word");
            void'(rxq.pop_front());
            nSink++;
        end
        if (scanDone)
            nDone++;
        if (prevHold && !u_pfci_if.holdN && mode == PF_ENC_BLK && nEnc != 0 && fallPos < 0)
            fallPos = int'(nEnc % 64);
        gapRun++;
        if (!prevHold && u_pfci_if.holdN) begin
            gapOn  = 1'b1;
            gapRun = 0;
        end
        if (gapOn && mode == PF_DEC_BLK && u_pfci_if.devSyncOe && !u_pfci_if.syncN) begin
            gapSeen = gapRun;
            gapOn   = 1'b0;
        end
        prevHold = u_pfci_if.holdN;
    end

    // hang guard, ceiling well above the expected run
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            close_out();
        end
    end

    initial begin
        tick(12);
        reset <= 1'b0;
        tick(4);
        chk_val(16'(u_pfci_if.holdN), 16'h0000, "idle hold-off");
        chk_val(16'(u_pfci_if.compIdx), 16'(COMP_IDLE), "idle index");
        // block encode: parameter load holds off, then five blocks against four buffers
        mode      <= PF_ENC_BLK;
        paramBusy <= 1'b1;
        tick(8);
        chk_val(16'(u_pfci_if.holdN), 16'h0000, "busy hold-off");
        chk_val(16'(u_pfci_if.devHoldOe), 16'h0001, "encode drive");
        paramBusy <= 1'b0;
        tick(8);
        chk_val(16'(u_pfci_if.holdN), 16'h0001, "ready hold-off");
        encBudget = 320;
        tick(900);
        chk_cnt(int'(nEnc % 64), 0, "stall on block edge");
        chk_cnt(int'(nEnc < 320), 1, "stalled before all blocks");
        chk_val(16'(u_pfci_if.holdN), 16'h0000, "full hold-off");
        chk_cnt(int'(fallPos >= 20 && fallPos <= 24), 1, "hold-off lead");
        for (int k = 0; k < 8 && nEnc < 320; k++) begin
            bufFree <= 1'b1;
            tick(1);
            bufFree <= 1'b0;
            tick(150);
        end
        chk_cnt(int'(nEnc), 320, "encode after free");
        // block decode: sink pauses, fifo fills until it refuses
        mode     <= PF_DEC_BLK;
        pauseReq <= 1'b1;
        tick(10);
        send_words(2'h0, 12'h100, 64);
        send_words(2'h1, 12'h200, 64);
        send_words(2'h2, 12'h300, 64);
        tick(100);
        chk_cnt(int'(nPush), int'(FIFO_DEPTH), "fifo fill");
        chk_val(16'(decReady), 16'h0000, "fifo refuses");
        pauseReq <= 1'b0;
        wait_cnt(nSink, 64);
        chk_cnt(int'(gapSeen >= 18), 1, "resume gap");
        wait_cnt(nSink, 80);
        pauseReq <= 1'b1;
        tick(300);
        chk_cnt(int'(nSink), 128, "next block withheld");
        pauseReq <= 1'b0;
        wait_cnt(nSink, 192);
        chk_cnt(int'(nSink), 192, "decode blocks");
        // per-sample modes: every index code, pause in mid-stream
        for (int m = 0; m < 2; m++) begin
            mode <= (m == 0) ? PF_DEC_PRV : PF_DEC_LSL;
            snap = nSink;
            for (int c = 0; c < 4; c++)
                send_words(2'(c), 12'h400 + 12'(16 * c), 4);
            wait_cnt(nSink, snap + 4);
            pauseReq <= 1'b1;
            tick(10);                      // samples already launched drain through the flops
            snap = nSink;
            tick(30);
            chk_cnt(int'(nSink), int'(snap), "stream held");
            pauseReq <= 1'b0;
            wait_cnt(nSink, 192 + 16 * (m + 1));
            chk_cnt(int'(nSink), 192 + 16 * (m + 1), "stream resumed");
        end
        // end of scan parks the index
        scanEnd <= 1'b1;
        tick(1);
        scanEnd <= 1'b0;
        tick(20);
        chk_cnt(int'(nDone), 1, "end of scan seen");
        chk_val(16'(u_pfci_if.compIdx), 16'(COMP_IDLE), "index after scan");
        // lossless encode: sink back-pressure holds the source off, then lets it finish
        mode      <= PF_ENC_LSL;
        encReady  <= 1'b0;
        encBudget = 40;
        tick(60);
        snap = nEnc;
        chk_val(16'(u_pfci_if.holdN), 16'h0000, "lossless hold-off");
        tick(30);
        chk_cnt(int'(nEnc), int'(snap), "lossless source stopped");
        encReady <= 1'b1;
        wait_cnt(nEnc, 360);
        chk_cnt(int'(nEnc), 360, "lossless resumed");
        close_out();
    end
endmodule // tb_pfci
